// ### logic/ric_pkg.sv
// Constants and types for reset, start-up and configuration store
// Operation
// R1: Stay in reset until the digital supply rises above the reset threshold voltage.
// R2: A reset pin held low past the minimum pulse time holds reset.
// R3: Leave reset no later than 1 ms after the reset pin returns high.
// R4: Every exit from reset runs an initialization phase of about 20 ms.
// R5: During initialization fan PWM pins drive low, all other outputs float.
// R6: After initialization, outputs follow the stored configuration.
// R7: Factory configuration floats general outputs, drives fan pins low, no sequencing.
// R8: A host parameter write changes only its working RAM word, never flash.
// R9: The store-all command copies the working RAM configuration into data flash.
// R10: A whole flash image may be loaded over the I2C or JTAG path.
// R11: Blank data flash at start-up enables the JTAG port.
// R12: Bad configuration checksum loads factory defaults, asserts alert, sets a flag.
// R13: Reset pin is synchronised and filtered; only full-length low pulses reset.
// R14: One init-done status gates all configured behaviour.
package ric_pkg;
  // Timing
  localparam int RIC_CLK_MHZ           = 125;
  localparam int RIC_MIN_RST_PULSE_NS  = 1000;
  localparam int RIC_MIN_RST_PULSE_CYC =
    (RIC_MIN_RST_PULSE_NS * RIC_CLK_MHZ + 999) / 1000;
  localparam int RIC_INIT_TIME_MS      = 20;
  localparam int RIC_INIT_CYC          = RIC_INIT_TIME_MS * 1000 * RIC_CLK_MHZ;
  localparam int RIC_RELEASE_MAX_MS    = 1;
  localparam int RIC_RELEASE_MAX_CYC   =
    RIC_RELEASE_MAX_MS * 1000 * RIC_CLK_MHZ;
  // Configuration image layout
  localparam int RIC_CFG_DEPTH   = 16;
  localparam int RIC_CFG_WIDTH   = 32;
  localparam int RIC_IDX_GPO_OE  = 0;
  localparam int RIC_IDX_GPO_VAL = 1;
  localparam int RIC_IDX_FAN_EN  = 2;
  localparam int RIC_IDX_CTRL    = 3;
  localparam int RIC_CTRL_SEQ    = 0;
  localparam int RIC_CTRL_FAULT  = 1;
  localparam logic [31:0] RIC_FACTORY_WORD = 32'h0000_0000;
  localparam logic [31:0] RIC_BLANK_WORD   = 32'hffff_ffff;
  // Reset values
  localparam logic RIC_SYNC_RST  = 1'h1;
  localparam logic RIC_HOLD_RST  = 1'h1;
  localparam logic RIC_ALERT_RST = 1'h1;
  localparam logic RIC_BLANK_RST = 1'h1;

  typedef enum logic [2:0] {
    RIC_RESET, RIC_SCAN, RIC_FILL, RIC_WAIT, RIC_RUN, RIC_STORE
  } ric_state_type;
endpackage : ric_pkg

// ### logic/ric_low_filter.sv
// Two-stage synchroniser and low-level length filter for a reset source
`timescale 1ns/1ns
`default_nettype none
module ric_low_filter #(
  parameter int LOW_CYCLES = ric_pkg::RIC_MIN_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous active-low level and filtered hold
  input  wire logic level_n,
  output logic      hold
);
  import ric_pkg::*;

  localparam int CW = $clog2(LOW_CYCLES + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic [CW-1:0] cnt;
    logic          hold;
  } ric_filt_type;

  ric_filt_type r;
  ric_filt_type nxt;

  // R13 sync and filter
  always_comb begin
    nxt    = r;
    nxt.s1 = level_n;
    nxt.s2 = r.s1;
    if (!r.s2) begin
      if (r.cnt == CW'(LOW_CYCLES - 1)) begin
        nxt.hold = 1'b1;
      end else begin
        nxt.cnt = r.cnt + CW'(1);
      end
    end else begin
      nxt.cnt  = '0;
      nxt.hold = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= '{s1: RIC_SYNC_RST, s2: RIC_SYNC_RST, cnt: '0,
             hold: RIC_HOLD_RST};
    end else begin
      r <= nxt;
    end
  end

  assign hold = r.hold;

  chk_filter_length : assert property ( // R13
    @(posedge mclk) disable iff (!rst_n)
    $rose(r.hold) |-> $past(r.cnt) == CW'(LOW_CYCLES - 1) && !$past(r.s2))
    else $error("hold rose before a full-length low level");
endmodule : ric_low_filter
`default_nettype wire

// ### logic/ric_reset_init_ctrl.sv
// Reset, initialization phase and configuration store controller
`timescale 1ns/1ns
`default_nettype none
module ric_reset_init_ctrl #(
  parameter int DEPTH        = ric_pkg::RIC_CFG_DEPTH,
  parameter int WIDTH        = ric_pkg::RIC_CFG_WIDTH,
  parameter int NGPO         = 16,
  parameter int NFAN         = 8,
  parameter int INIT_CYCLES  = ric_pkg::RIC_INIT_CYC,
  parameter int PULSE_CYCLES = ric_pkg::RIC_MIN_RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // Supply monitor and reset pin
  input  wire logic                     supply_ok,
  input  wire logic                     reset_pin_n,
  // Parameter writes and commands
  input  wire logic                     cfg_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] cfg_wr_addr,
  input  wire logic [WIDTH-1:0]         cfg_wr_data,
  input  wire logic                     store_all_cmd,
  input  wire logic                     alert_clr,
  // Flash image load
  input  wire logic                     img_wr_en,
  input  wire logic                     img_from_jtag,
  input  wire logic [$clog2(DEPTH)-1:0] img_addr,
  input  wire logic [WIDTH-1:0]         img_data,
  // Fan PWM source
  input  wire logic [NFAN-1:0]          fan_pwm_req,
  // Pins
  output logic [NGPO-1:0]               gpo_out,
  output logic [NGPO-1:0]               gpo_oe,
  output logic [NFAN-1:0]               fan_pwm_pins,
  // Status
  output logic                          init_done,
  output logic                          jtag_en,
  output logic                          alert_n,
  output logic                          cksum_bad,
  output logic                          seq_en,
  output logic                          fault_en,
  output logic                          store_busy
);
  import ric_pkg::*;

  localparam int AW   = $clog2(DEPTH);
  localparam int CW   = $clog2(INIT_CYCLES + 1);
  localparam int LAST = DEPTH - 1;

  typedef struct packed {
    ric_state_type    st;
    logic [CW-1:0]    cnt;
    logic [AW-1:0]    idx;
    logic [WIDTH-1:0] sum;
    logic             blank;
    logic             init_done;
    logic             jtag_en;
    logic             alert_n;
    logic             cksum_bad;
    logic             seq_en;
    logic             fault_en;
    logic             store_busy;
    logic [NGPO-1:0]  gpo_out;
    logic [NGPO-1:0]  gpo_oe;
    logic [NFAN-1:0]  fan;
  } ric_core_type;

  localparam ric_core_type CORE_RST = '{
    st: RIC_RESET, cnt: '0, idx: '0, sum: '0, blank: RIC_BLANK_RST,
    init_done: 1'b0, jtag_en: 1'b0, alert_n: RIC_ALERT_RST,
    cksum_bad: 1'b0, seq_en: 1'b0, fault_en: 1'b0, store_busy: 1'b0,
    gpo_out: '0, gpo_oe: '0, fan: '0};

  ric_core_type     r;
  ric_core_type     nxt;
  logic [WIDTH-1:0] ram   [DEPTH];
  logic [WIDTH-1:0] flash [DEPTH] = '{default: WIDTH'(RIC_BLANK_WORD)};
  logic             ram_we;
  logic [AW-1:0]    ram_wa;
  logic [WIDTH-1:0] ram_wd;
  logic             flash_we;
  logic [AW-1:0]    flash_wa;
  logic [WIDTH-1:0] flash_wd;
  logic             por_hold;
  logic             pin_hold;
  logic             dev_rst;

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // R1 supply detector
  ric_low_filter #(.LOW_CYCLES(1)) u_por (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .level_n (supply_ok),
    .hold    (por_hold)
  );

  // R13 pin filter
  ric_low_filter #(.LOW_CYCLES(PULSE_CYCLES)) u_pin (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .level_n (reset_pin_n),
    .hold    (pin_hold)
  );

  assign dev_rst = por_hold | pin_hold;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt      = r;
    ram_we   = 1'b0;
    ram_wa   = r.idx;
    ram_wd   = flash[r.idx];
    flash_we = 1'b0;
    flash_wa = r.idx;
    flash_wd = ram[r.idx];
    if (dev_rst) begin
      // R2 hold in reset
      nxt.st         = RIC_RESET;
      nxt.init_done  = 1'b0;
      // R5 pins quiet
      nxt.gpo_oe     = '0;
      nxt.fan        = '0;
      nxt.seq_en     = 1'b0;
      nxt.fault_en   = 1'b0;
      nxt.store_busy = 1'b0;
      nxt.cnt        = '0;
      nxt.idx        = '0;
      nxt.sum        = '0;
      nxt.blank      = RIC_BLANK_RST;
    end else begin
      if (alert_clr) begin
        nxt.alert_n   = RIC_ALERT_RST;
        nxt.cksum_bad = 1'b0;
      end
      // R4 init timer
      if (r.st != RIC_RUN && r.st != RIC_STORE &&
          r.cnt != CW'(INIT_CYCLES - 1)) begin
        nxt.cnt = r.cnt + CW'(1);
      end
      // R6 run from config
      if (r.st == RIC_RUN || r.st == RIC_STORE) begin
        nxt.gpo_oe   = ram[RIC_IDX_GPO_OE][NGPO-1:0];
        nxt.gpo_out  = ram[RIC_IDX_GPO_VAL][NGPO-1:0];
        nxt.fan      = fan_pwm_req & ram[RIC_IDX_FAN_EN][NFAN-1:0];
        nxt.seq_en   = ram[RIC_IDX_CTRL][RIC_CTRL_SEQ];
        nxt.fault_en = ram[RIC_IDX_CTRL][RIC_CTRL_FAULT];
      end
      unique case (r.st)
        RIC_RESET: begin
          // R3 prompt release
          nxt.st = RIC_SCAN;
        end
        RIC_SCAN: begin
          ram_we = 1'b1;
          if (flash[r.idx] != WIDTH'(RIC_BLANK_WORD)) begin
            nxt.blank = 1'b0;
          end
          if (r.idx == AW'(LAST)) begin
            nxt.idx = '0;
            // R11 blank flash
            nxt.jtag_en = r.blank && flash[r.idx] == WIDTH'(RIC_BLANK_WORD);
            // R12 checksum fail
            if (r.sum != flash[r.idx]) begin
              nxt.cksum_bad = 1'b1;
              nxt.alert_n   = 1'b0;
              nxt.st        = RIC_FILL;
            end else begin
              nxt.st = RIC_WAIT;
            end
          end else begin
            nxt.sum = r.sum + flash[r.idx];
            nxt.idx = r.idx + AW'(1);
          end
        end
        RIC_FILL: begin
          // R7 factory defaults
          ram_we  = 1'b1;
          ram_wd  = WIDTH'(RIC_FACTORY_WORD);
          nxt.idx = r.idx + AW'(1);
          if (r.idx == AW'(LAST)) begin
            nxt.st = RIC_WAIT;
          end
        end
        RIC_WAIT: begin
          // R14 init done
          if (r.cnt == CW'(INIT_CYCLES - 1)) begin
            nxt.st        = RIC_RUN;
            nxt.init_done = 1'b1;
          end
        end
        RIC_RUN: begin
          if (store_all_cmd) begin
            nxt.st         = RIC_STORE;
            nxt.idx        = '0;
            nxt.sum        = '0;
            nxt.store_busy = 1'b1;
          end else if (cfg_wr_en) begin
            // R8 RAM only
            ram_we = 1'b1;
            ram_wa = cfg_wr_addr;
            ram_wd = cfg_wr_data;
          end
          // R10 image load
          if (img_wr_en && (!img_from_jtag || r.jtag_en)) begin
            flash_we = 1'b1;
            flash_wa = img_addr;
            flash_wd = img_data;
          end
        end
        RIC_STORE: begin
          // R9 copy to flash
          flash_we = 1'b1;
          if (r.idx == AW'(LAST)) begin
            flash_wd       = r.sum;
            nxt.st         = RIC_RUN;
            nxt.store_busy = 1'b0;
          end else begin
            nxt.sum = r.sum + ram[r.idx];
            nxt.idx = r.idx + AW'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= CORE_RST;
    end else begin
      r <= nxt;
    end
  end

  // ****************************************************************
  // Working RAM and data flash
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
    if (flash_we) begin
      flash[flash_wa] <= flash_wd;
    end
  end

  assign gpo_out      = r.gpo_out;
  assign gpo_oe       = r.gpo_oe;
  assign fan_pwm_pins = r.fan;
  assign init_done    = r.init_done;
  assign jtag_en      = r.jtag_en;
  assign alert_n      = r.alert_n;
  assign cksum_bad    = r.cksum_bad;
  assign seq_en       = r.seq_en;
  assign fault_en     = r.fault_en;
  assign store_busy   = r.store_busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_por_hold : assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    por_hold |=> r.st == RIC_RESET && !r.init_done)
    else $error("supply low but device not in reset");

  chk_pin_hold : assert property ( // R2
    @(posedge mclk) disable iff (!rst_n)
    pin_hold |=> r.st == RIC_RESET)
    else $error("reset pin held but device not in reset");

  chk_release_time : assert property ( // R3
    @(posedge mclk) disable iff (!rst_n)
    $fell(pin_hold) && !por_hold |-> ##1 r.st == RIC_SCAN)
    else $error("reset release too slow");

  chk_init_length : assert property ( // R4
    @(posedge mclk) disable iff (!rst_n)
    $rose(r.init_done) |-> $past(r.cnt) == CW'(INIT_CYCLES - 1))
    else $error("initialization phase length wrong");

  chk_init_pins : assert property ( // R5
    @(posedge mclk) disable iff (!rst_n)
    !r.init_done |-> r.fan == '0 && r.gpo_oe == '0)
    else $error("pins driven during initialization");

  chk_factory_fill : assert property ( // R7
    @(posedge mclk) disable iff (!rst_n)
    r.st == RIC_WAIT && $past(r.st) == RIC_FILL |->
      ram[RIC_IDX_CTRL] == WIDTH'(RIC_FACTORY_WORD) &&
      ram[RIC_IDX_FAN_EN] == WIDTH'(RIC_FACTORY_WORD))
    else $error("factory defaults not loaded");

  chk_ram_only : assert property ( // R8
    @(posedge mclk) disable iff (!rst_n)
    r.st == RIC_RUN && !dev_rst && cfg_wr_en && !store_all_cmd &&
      !img_wr_en |-> ram_we && !flash_we && ram_wd == cfg_wr_data)
    else $error("parameter write touched flash");

  chk_store_sum : assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    r.st == RIC_STORE && r.idx == AW'(LAST) && !dev_rst |=>
      flash[LAST] == $past(r.sum) && r.st == RIC_RUN)
    else $error("store did not commit checksum");

  chk_jtag_gate : assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    r.st == RIC_RUN && img_wr_en && img_from_jtag && !r.jtag_en |->
      !flash_we)
    else $error("image taken on disabled JTAG path");

  chk_blank_jtag : assert property ( // R11
    @(posedge mclk) disable iff (!rst_n)
    r.st == RIC_SCAN && r.idx == AW'(LAST) && r.blank && !dev_rst &&
      flash[LAST] == WIDTH'(RIC_BLANK_WORD) |=> r.jtag_en)
    else $error("blank flash did not enable JTAG");

  chk_bad_alert : assert property ( // R12
    @(posedge mclk) disable iff (!rst_n)
    $rose(r.cksum_bad) |-> !r.alert_n && r.st == RIC_FILL)
    else $error("checksum failure without alert");

  chk_done_run : assert property ( // R14
    @(posedge mclk) disable iff (!rst_n)
    r.init_done |-> r.st == RIC_RUN || r.st == RIC_STORE)
    else $error("init done outside normal operation");
endmodule : ric_reset_init_ctrl
`default_nettype wire

// ### verif/ric_host_model.sv
// Host and programmer model issuing parameter, store and image requests
`timescale 1ns/1ns
`default_nettype none
module ric_host_model (
  // Clock
  input  wire logic  mclk,
  // Parameter writes and store command
  output logic        cfg_wr_en,
  output logic [3:0]  cfg_wr_addr,
  output logic [31:0] cfg_wr_data,
  output logic        store_all_cmd,
  // Flash image load
  output logic        img_wr_en,
  output logic        img_from_jtag,
  output logic [3:0]  img_addr,
  output logic [31:0] img_data
);
  initial begin
    cfg_wr_en = 1'h0;
    cfg_wr_addr = 4'h0;
    cfg_wr_data = 32'h0;
    store_all_cmd = 1'h0;
    img_wr_en = 1'h0;
    img_from_jtag = 1'h0;
    img_addr = 4'h0;
    img_data = 32'h0;
  end

  task automatic write_word(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cfg_wr_en <= 1'h1;
    cfg_wr_addr <= a;
    cfg_wr_data <= d;
    @(posedge mclk);
    cfg_wr_en <= 1'h0;
    cfg_wr_data <= ~d;
  endtask : write_word

  task automatic store_all();
    @(posedge mclk);
    store_all_cmd <= 1'h1;
    @(posedge mclk);
    store_all_cmd <= 1'h0;
  endtask : store_all

  task automatic load_image(input logic j, input logic [31:0] w0, w1, w2, w3);
    logic [31:0] wd [16];
    wd = '{default: 32'h0};
    wd[0] = w0;
    wd[1] = w1;
    wd[2] = w2;
    wd[3] = w3;
    wd[15] = w0 + w1 + w2 + w3;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      img_wr_en <= 1'h1;
      img_from_jtag <= j;
      img_addr <= 4'(i);
      img_data <= wd[i];
    end
    @(posedge mclk);
    img_wr_en <= 1'h0;
    img_data <= ~wd[15];
  endtask : load_image
endmodule : ric_host_model
`default_nettype wire

// ### verif/ric_reset_init_ctrl_tb.sv
// Self-checking bench for the reset and configuration store controller
`timescale 1ns/1ns
`default_nettype none
module ric_reset_init_ctrl_tb;
  import ric_pkg::*;
  localparam int INIT  = 100;
  localparam int PULSE = 4;
  localparam int LIMIT = INIT + 2 * RIC_CFG_DEPTH + 20;
  logic        mclk, rst_n, supply_ok, reset_pin_n, alert_clr;
  logic        cfg_wr_en, store_all_cmd, img_wr_en, img_from_jtag;
  logic [3:0]  cfg_wr_addr, img_addr;
  logic [31:0] cfg_wr_data, img_data;
  logic [7:0]  fan_pwm_req, fan_pwm_pins;
  logic [15:0] gpo_out, gpo_oe;
  logic        init_done, jtag_en, alert_n, cksum_bad;
  logic        seq_en, fault_en, store_busy;
  int          mismatches, total_checks;

  ric_reset_init_ctrl #(
    .INIT_CYCLES(INIT), .PULSE_CYCLES(PULSE)
  ) u_ric_reset_init_ctrl (
    .mclk(mclk), .rst_n(rst_n), .supply_ok(supply_ok),
    .reset_pin_n(reset_pin_n), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
    .store_all_cmd(store_all_cmd), .alert_clr(alert_clr),
    .img_wr_en(img_wr_en), .img_from_jtag(img_from_jtag),
    .img_addr(img_addr), .img_data(img_data), .fan_pwm_req(fan_pwm_req),
    .gpo_out(gpo_out), .gpo_oe(gpo_oe), .fan_pwm_pins(fan_pwm_pins),
    .init_done(init_done), .jtag_en(jtag_en), .alert_n(alert_n),
    .cksum_bad(cksum_bad), .seq_en(seq_en), .fault_en(fault_en),
    .store_busy(store_busy));

  ric_host_model u_ric_host_model (
    .mclk(mclk), .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .store_all_cmd(store_all_cmd),
    .img_wr_en(img_wr_en), .img_from_jtag(img_from_jtag),
    .img_addr(img_addr), .img_data(img_data));

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'h1 && n < LIMIT) begin
      tick(1);
      n++;
      if (init_done !== 1'h1) begin
        chk({gpo_oe, fan_pwm_pins}, 24'h0, "pins active in init");
      end
    end
    chk(32'(n >= INIT && n < LIMIT), 32'h1, "init length");
    tick(1);
  endtask : wait_init

  task automatic pin_reset(input int len, input logic hit);
    @(posedge mclk);
    reset_pin_n <= 1'h0;
    tick(len);
    if (hit) begin
      chk({init_done, gpo_oe}, 17'h0, "reset not entered");
    end
    @(posedge mclk);
    reset_pin_n <= 1'h1;
    if (hit) begin
      wait_init();
    end
  endtask : pin_reset

  task automatic t_power_on();
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    wait_init();
    chk({jtag_en, cksum_bad, alert_n}, 3'h6, "blank flash");
    chk({gpo_oe, fan_pwm_pins, seq_en, fault_en}, 0, "factory");
    @(posedge mclk);
    alert_clr <= 1'h1;
    @(posedge mclk);
    alert_clr <= 1'h0;
    tick(2);
    chk({alert_n, cksum_bad}, 2'h2, "alert clear");
  endtask : t_power_on

  task automatic set_cfg(input logic [31:0] oe);
    u_ric_host_model.write_word(4'h0, oe);
    u_ric_host_model.write_word(4'h1, 32'h00a5);
    u_ric_host_model.write_word(4'h2, 32'h000f);
    u_ric_host_model.write_word(4'h3, 32'h0003);
    tick(3);
  endtask : set_cfg

  task automatic t_jtag_image();
    u_ric_host_model.load_image(1'h1, 32'h3, 32'h1, 32'h0, 32'h0);
    pin_reset(PULSE + 10, 1'h1);
    chk(gpo_oe, 16'h0003, "jtag image");
    chk({jtag_en, cksum_bad, alert_n}, 3'h1, "good flash");
  endtask : t_jtag_image

  task automatic t_glitch();
    pin_reset(PULSE - 2, 1'h0);
    tick(12);
    chk(init_done, 1'h1, "glitch reset");
  endtask : t_glitch

  task automatic t_cfg_write();
    set_cfg(32'h00ff);
    chk(gpo_oe, 16'h00ff, "ram oe");
    chk(gpo_out & gpo_oe, 16'h00a5, "ram value");
    chk(fan_pwm_pins, 8'h0a, "fan mask");
    chk({seq_en, fault_en}, 2'h3, "ctrl bits");
    pin_reset(PULSE + 10, 1'h1);
    chk(gpo_oe, 16'h0003, "flash changed by write");
  endtask : t_cfg_write

  task automatic t_store();
    int b;
    b = 0;
    set_cfg(32'h00ff);
    u_ric_host_model.store_all();
    tick(1);
    while (store_busy === 1'h1 && b < 40) begin
      tick(1);
      b++;
    end
    chk(b + 1, RIC_CFG_DEPTH, "store length");
    pin_reset(PULSE + 10, 1'h1);
    chk(gpo_oe, 16'h00ff, "stored oe");
    chk({fan_pwm_pins, seq_en, cksum_bad}, 10'h2a, "stored cfg");
  endtask : t_store

  task automatic t_i2c_image();
    u_ric_host_model.load_image(1'h0, 32'h0f0f, 32'h0, 32'h0, 32'h0);
    u_ric_host_model.load_image(1'h1, 32'hffff, 32'h0, 32'h0, 32'h0);
    pin_reset(PULSE + 10, 1'h1);
    chk(gpo_oe, 16'h0f0f, "i2c image");
  endtask : t_i2c_image

  task automatic t_supply();
    @(posedge mclk);
    supply_ok <= 1'h0;
    tick(6);
    chk({init_done, fan_pwm_pins}, 9'h0, "supply reset");
    @(posedge mclk);
    supply_ok <= 1'h1;
    wait_init();
    chk(gpo_oe, 16'h0f0f, "after supply");
  endtask : t_supply

  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_n = 1'h0;
    supply_ok = 1'h1;
    reset_pin_n = 1'h1;
    alert_clr = 1'h0;
    fan_pwm_req = 8'h5a;
    t_power_on();
    t_jtag_image();
    t_glitch();
    t_cfg_write();
    t_store();
    t_i2c_image();
    t_supply();
    stop_test();
  end

  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : ric_reset_init_ctrl_tb
`default_nettype wire
